// [shared/srra_consts.svh]
`ifndef SRRA_CONSTS_SVH
`define SRRA_CONSTS_SVH

// control byte fields
`define SRRA_CTL_BCAST    7
`define SRRA_CTL_READ     6
`define SRRA_CTL_REG      5
`define SRRA_CTL_CID0     3
`define SRRA_CTL_CID1     2
`define SRRA_CTL_CID2     1
`define SRRA_CTL_CID3     0

// serial bit counting
`define SRRA_CNT_ZERO     4'h0
`define SRRA_CNT_ONE      4'h1
`define SRRA_CNT_BYTE_END 3'h7
`define SRRA_CNT_WORD_END 4'hF
`define SRRA_CNT_CID0     4'h4
`define SRRA_CNT_CID1     4'h5
`define SRRA_CNT_BYTE_START 3'h0

// channel id and register file
`define SRRA_CID_CH0      4'h0
`define SRRA_CID_CH1      4'h1
`define SRRA_REG_DEPTH    16
`define SRRA_REG_LIMIT    8'h10
`define SRRA_STAT_ADDR    8'h0F
`define SRRA_REG_RESET    8'h00
`define SRRA_ADDR_RESET   8'h00
`define SRRA_WORD_RESET   16'h0000
`define SRRA_SH_RESET     15'h0000
`define SRRA_STAT_FILL    15'h0000
`define SRRA_BYTE_FILL    8'h00
`define SRRA_PAIR_RESET   2'h0
`define SRRA_SEL_NONE     2'h0
`define SRRA_SEL_CH0      2'h1
`define SRRA_SEL_CH1      2'h2
`define SRRA_SEL_ALL      2'h3

`endif

// [shared/srra_pkg.sv]
package srra_pkg;

  // serial transfer phase
  typedef enum logic [3:0] {
    SRRA_PH_CTRL = 4'h1,
    SRRA_PH_ADDR = 4'h2,
    SRRA_PH_DATA = 4'h4,
    SRRA_PH_PAD  = 4'h8
  } srra_phase_t;

  // processor service sequence
  typedef enum logic [2:0] {
    SRRA_SV_IDLE = 3'h1,
    SRRA_SV_CH0  = 3'h2,
    SRRA_SV_CH1  = 3'h4
  } srra_svc_t;

endpackage : srra_pkg

// [logic/srra_spi_ram_access.sv]
`timescale 1ns/1ps
`include "srra_consts.svh"

module srra_spi_ram_access
  import srra_pkg::*;
(
  // system
  input  wire logic        mclk,
  input  wire logic        rst,
  // serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  output logic             chain_data_out,
  // processor ram service
  input  wire logic        svc_slot,
  input  wire logic [15:0] ram_rdata,
  output logic             ram_strobe,
  output logic             ram_ch,
  output logic             ram_we,
  output logic [7:0]       ram_addr,
  output logic [15:0]      ram_wdata,
  // per-channel status
  output logic [1:0]       ram_pending_flag,
  output logic [1:0]       ram_done
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] srra_target(input logic [7:0] ctl);
    logic [3:0] channel_id;
    channel_id = {ctl[`SRRA_CTL_CID3], ctl[`SRRA_CTL_CID2], ctl[`SRRA_CTL_CID1], ctl[`SRRA_CTL_CID0]};
    if (ctl[`SRRA_CTL_BCAST]) begin
      srra_target = ctl[`SRRA_CTL_READ] ? `SRRA_SEL_NONE : `SRRA_SEL_ALL;
    end else if (channel_id == `SRRA_CID_CH0) begin
      srra_target = `SRRA_SEL_CH0;
    end else if (channel_id == `SRRA_CID_CH1) begin
      srra_target = `SRRA_SEL_CH1;
    end else begin
      srra_target = `SRRA_SEL_NONE;
    end
  endfunction : srra_target

  function automatic logic srra_reg_slot(input logic [7:0] a);
    srra_reg_slot = (a < `SRRA_REG_LIMIT) && (a != `SRRA_STAT_ADDR);
  endfunction : srra_reg_slot

  //////////////////////////////////////////////////////////////////////////////
  // link domain state
  logic              rst_s1;
  logic              rst_s2;
  srra_phase_t       phase;
  logic [3:0]        cnt;
  logic [3:0]        next_cnt;
  logic [14:0]       sh;
  logic              broadcast_flag;
  logic              borrow;
  logic [1:0]        sel;
  logic              rd;
  logic              regsel;
  logic [7:0]        addr;
  logic [15:0]       tx_word;
  logic [7:0]        regs [2][`SRRA_REG_DEPTH];
  logic [1:0]        req_tgl;
  logic [1:0]        req_wr;
  logic [7:0]        req_addr [2];
  logic [15:0]       req_data [2];
  logic [7:0]        addr_buf [2];
  logic [15:0]       data_buf [2];
  logic [1:0]        pend_s1;
  logic [1:0]        pend_s2;
  logic [7:0]        rx_byte;
  logic [15:0]       rx_word;
  logic              ctrl_done;
  logic              addr_done;
  logic              data_done;
  logic              pad_done;
  logic              rd_ch;
  logic              drive;

  //////////////////////////////////////////////////////////////////////////////
  // link domain strobes
  assign rx_byte   = {sh[6:0], sdi};
  assign rx_word   = {sh, sdi};
  assign ctrl_done = !cs_n && (phase == SRRA_PH_CTRL) && (cnt[2:0] == `SRRA_CNT_BYTE_END);
  assign addr_done = !cs_n && (phase == SRRA_PH_ADDR) && (cnt[2:0] == `SRRA_CNT_BYTE_END);
  assign data_done = !cs_n && (phase == SRRA_PH_DATA) &&
                     (regsel ? (cnt[2:0] == `SRRA_CNT_BYTE_END) : (cnt == `SRRA_CNT_WORD_END));
  assign pad_done  = !cs_n && (phase == SRRA_PH_PAD) && (cnt[2:0] == `SRRA_CNT_BYTE_END);
  assign rd_ch     = sel[1];
  assign drive     = rd && (sel != `SRRA_SEL_NONE) && ((phase == SRRA_PH_DATA) || (phase == SRRA_PH_PAD));

  always_comb begin
    next_cnt = cnt + `SRRA_CNT_ONE;
    if (ctrl_done || addr_done || pad_done || (data_done && regsel)) begin
      next_cnt = `SRRA_CNT_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link reset synchroniser
  always_ff @(posedge sclk) begin
    rst_s1 <= rst;
    rst_s2 <= rst_s1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // phase and bit count
  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      phase <= SRRA_PH_CTRL;
      cnt   <= `SRRA_CNT_ZERO;
    end else if (cs_n) begin
      if ((cnt[2:0] != `SRRA_CNT_BYTE_START) || (phase == SRRA_PH_PAD)) begin
        phase <= SRRA_PH_CTRL;
        cnt   <= `SRRA_CNT_ZERO;
      end
    end else begin
      cnt <= next_cnt;
      case (phase)
        SRRA_PH_CTRL: phase <= ctrl_done ? SRRA_PH_ADDR : SRRA_PH_CTRL;
        SRRA_PH_ADDR: phase <= addr_done ? SRRA_PH_DATA : SRRA_PH_ADDR;
        SRRA_PH_DATA: phase <= data_done ? (regsel ? SRRA_PH_PAD : SRRA_PH_CTRL) : SRRA_PH_DATA;
        SRRA_PH_PAD:  phase <= pad_done ? SRRA_PH_CTRL : SRRA_PH_PAD;
        default:      phase <= SRRA_PH_CTRL;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive shift and control decode
  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      sh <= `SRRA_SH_RESET;
    end else if (!cs_n) begin
      sh <= rx_word[14:0];
    end
  end

  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      sel    <= `SRRA_SEL_NONE;
      rd     <= 1'b0;
      regsel <= 1'b0;
      addr   <= `SRRA_ADDR_RESET;
    end else if (ctrl_done) begin
      sel    <= srra_target(rx_byte);
      rd     <= rx_byte[`SRRA_CTL_READ];
      regsel <= rx_byte[`SRRA_CTL_REG];
    end else if (addr_done) begin
      addr <= rx_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // chain pass-through with serial id decrement by two
  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      broadcast_flag <= 1'b0;
      borrow         <= 1'b0;
    end else if (!cs_n && (phase == SRRA_PH_CTRL)) begin
      if (cnt == `SRRA_CNT_ZERO) begin
        broadcast_flag <= sdi;
      end
      if (cnt == `SRRA_CNT_CID0) begin
        borrow <= 1'b1;
      end else if (cnt >= `SRRA_CNT_CID1) begin
        borrow <= borrow && !sdi;
      end
    end
  end

  always_comb begin
    chain_data_out = sdi;
    if (!cs_n && (phase == SRRA_PH_CTRL) && (cnt >= `SRRA_CNT_CID1) && !broadcast_flag) begin
      chain_data_out = sdi ^ borrow;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit word load
  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      tx_word <= `SRRA_WORD_RESET;
    end else if (addr_done && rd) begin
      if (regsel) begin
        if (rx_byte == `SRRA_STAT_ADDR) begin
          tx_word <= {`SRRA_STAT_FILL, pend_s2[rd_ch]};
        end else if (srra_reg_slot(rx_byte)) begin
          tx_word <= {`SRRA_BYTE_FILL, regs[rd_ch][rx_byte[3:0]]};
        end else begin
          tx_word <= `SRRA_WORD_RESET;
        end
      end else begin
        tx_word <= pend_s2[rd_ch] ? `SRRA_WORD_RESET : data_buf[rd_ch];
      end
    end
  end

  always_ff @(negedge sclk) begin
    if (rst_s2) begin
      sdo      <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= !(drive && !cs_n);
      if (regsel) begin
        sdo <= tx_word[`SRRA_CNT_BYTE_END - cnt[2:0]];
      end else begin
        sdo <= tx_word[`SRRA_CNT_WORD_END - cnt];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      for (int c = 0; c < 2; c++) begin
        for (int r = 0; r < `SRRA_REG_DEPTH; r++) begin
          regs[c][r] <= `SRRA_REG_RESET;
        end
      end
    end else if (data_done && regsel && !rd && srra_reg_slot(addr)) begin
      for (int c = 0; c < 2; c++) begin
        if (sel[c]) begin
          regs[c][addr[3:0]] <= rx_byte;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // ram request capture per channel
  always_ff @(posedge sclk) begin
    if (rst_s2) begin
      req_tgl <= `SRRA_PAIR_RESET;
      req_wr  <= `SRRA_PAIR_RESET;
      for (int c = 0; c < 2; c++) begin
        req_addr[c] <= `SRRA_ADDR_RESET;
        req_data[c] <= `SRRA_WORD_RESET;
      end
    end else if (data_done && !regsel) begin
      for (int c = 0; c < 2; c++) begin
        if (sel[c]) begin
          req_addr[c] <= addr;
          req_wr[c]   <= !rd;
          req_tgl[c]  <= !req_tgl[c];
          if (!rd) begin
            req_data[c] <= rx_word;
          end
        end
      end
    end
  end

  always_ff @(posedge sclk) begin
    pend_s1 <= ram_pending_flag;
    pend_s2 <= pend_s1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // processor domain
  logic [1:0]  tgl_s1;
  logic [1:0]  tgl_s2;
  logic [1:0]  tgl_s3;
  logic [1:0]  req_ev;
  logic [1:0]  wr_buf;
  srra_svc_t   svc;
  srra_svc_t   next_svc;
  logic [1:0]  served;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tgl_s1 <= `SRRA_PAIR_RESET;
      tgl_s2 <= `SRRA_PAIR_RESET;
      tgl_s3 <= `SRRA_PAIR_RESET;
    end else begin
      tgl_s1 <= req_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign req_ev = tgl_s2 ^ tgl_s3;

  always_comb begin
    case (svc)
      SRRA_SV_IDLE: next_svc = svc_slot ? SRRA_SV_CH0 : SRRA_SV_IDLE;
      SRRA_SV_CH0:  next_svc = SRRA_SV_CH1;
      SRRA_SV_CH1:  next_svc = SRRA_SV_IDLE;
      default:      next_svc = SRRA_SV_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      svc <= SRRA_SV_IDLE;
    end else begin
      svc <= next_svc;
    end
  end

  assign served[0]  = (svc == SRRA_SV_CH0) && ram_pending_flag[0];
  assign served[1]  = (svc == SRRA_SV_CH1) && ram_pending_flag[1];
  assign ram_strobe = |served;
  assign ram_ch     = served[1];
  assign ram_we     = wr_buf[ram_ch];
  assign ram_addr   = addr_buf[ram_ch];
  assign ram_wdata  = data_buf[ram_ch];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ram_pending_flag <= `SRRA_PAIR_RESET;
      ram_done         <= `SRRA_PAIR_RESET;
      wr_buf           <= `SRRA_PAIR_RESET;
      for (int c = 0; c < 2; c++) begin
        addr_buf[c] <= `SRRA_ADDR_RESET;
        data_buf[c] <= `SRRA_WORD_RESET;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        ram_done[c] <= served[c];
        if (req_ev[c]) begin
          ram_pending_flag[c] <= 1'b1;
          addr_buf[c]         <= req_addr[c];
          wr_buf[c]           <= req_wr[c];
          if (req_wr[c]) begin
            data_buf[c] <= req_data[c];
          end
        end else if (served[c]) begin
          ram_pending_flag[c] <= 1'b0;
          if (!wr_buf[c]) begin
            data_buf[c] <= ram_rdata;
          end
        end
      end
    end
  end

endmodule : srra_spi_ram_access

// [verif/srra_spi_ram_access_properties.sv]
`timescale 1ns/1ps
module srra_spi_ram_access_properties (
  // system
  input  wire logic       mclk,
  input  wire logic       rst,
  // processor ram service
  input  wire logic       svc_slot,
  input  wire logic       ram_strobe,
  input  wire logic       ram_ch,
  // per-channel status
  input  wire logic [1:0] ram_pending_flag,
  input  wire logic [1:0] ram_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  slot_to_strobe_a: assert property (ram_strobe |-> $past(svc_slot) || $past(svc_slot, 2))
    else $error("strobe outside a service slot");
  slot_order_a: assert property (ram_strobe && ram_ch |-> $past(svc_slot, 2))
    else $error("second channel strobe not two cycles after slot");
  strobe_pending_a: assert property (ram_strobe |-> ram_pending_flag[ram_ch])
    else $error("strobe without pending request");
  strobe_single_a: assert property (ram_strobe && !ram_ch |=> !ram_strobe || ram_ch)
    else $error("first channel strobed twice");
  done_first_a: assert property (ram_strobe && !ram_ch |=> ram_done == 2'h1)
    else $error("first channel done pulse wrong");
  done_second_a: assert property (ram_strobe && ram_ch |=> ram_done == 2'h2)
    else $error("second channel done pulse wrong");
  done_cause_a: assert property (ram_done != 2'h0 |-> $past(ram_strobe))
    else $error("done pulse without strobe");
  pend_clear_a: assert property (ram_done[0] |-> !ram_pending_flag[0])
    else $error("pending not cleared with done");
  pend_fall_a: assert property ($fell(ram_pending_flag[1]) |-> ram_done[1])
    else $error("pending dropped without done");
endmodule : srra_spi_ram_access_properties

bind srra_spi_ram_access srra_spi_ram_access_properties u_srra_spi_ram_access_properties (
  .mclk, .rst, .svc_slot, .ram_strobe, .ram_ch, .ram_pending_flag, .ram_done);

// [verif/srra_host_model.sv]
`timescale 1ns/1ps
module srra_host_model (
  // serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n,
  input  wire logic chain_data_out
);
  logic sdo_w;
  // pulldown on the released data line
  assign sdo_w = sdo_oe_n ? 1'b0 : sdo;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx, ch);
    int i;
    rx = 32'h0;
    ch = 32'h0;
    cs_n = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #7.5;
      rx = {rx[30:0], sdo_w};
      ch = {ch[30:0], chain_data_out};
      sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (3) begin
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
  endtask : xfer
endmodule : srra_host_model

// [verif/test_spi_register_ram_access.sv]
`timescale 1ns/1ps
module test_spi_register_ram_access;
  logic        mclk      = 1'b0;
  logic        rst       = 1'b1;
  logic        svc_slot  = 1'b0;
  logic [15:0] ram_rdata = 16'h0000;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, chain_data_out;
  logic        ram_strobe, ram_ch, ram_we;
  logic [7:0]  ram_addr;
  logic [15:0] ram_wdata;
  logic [1:0]  ram_pending_flag, ram_done;
  logic [31:0] rx, ch, la;
  logic [23:0] rd [4] = '{24'h6003A5, 24'h680377, 24'h600599, 24'h680599};
  int          miscompares = 0;
  int          compares    = 0;
  int          nacc        = 0;
  always #10 mclk = ~mclk;
  srra_spi_ram_access u_srra_spi_ram_access (.mclk, .rst, .sclk, .cs_n, .sdi, .sdo, .sdo_oe_n,
    .chain_data_out, .svc_slot, .ram_rdata, .ram_strobe, .ram_ch, .ram_we, .ram_addr,
    .ram_wdata, .ram_pending_flag, .ram_done);
  srra_host_model u_srra_host_model (.sclk, .cs_n, .sdi, .sdo, .sdo_oe_n, .chain_data_out);
  // processor side: log each access
  always @(posedge mclk) begin
    if (ram_strobe === 1'b1) begin
      nacc <= nacc + 1;
      la   <= {ram_we, 7'h00, ram_addr, ram_wdata};
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic sp(input logic [31:0] tx, input int n);
    u_srra_host_model.xfer(tx, n, rx, ch);
  endtask : sp
  task automatic waitp(input logic [1:0] e);
    int i;
    for (i = 0; i < 200 && ram_pending_flag !== e; i++) @(negedge mclk);
    chk("pending", {30'h0, ram_pending_flag}, {30'h0, e});
    if (i == 200) results();
  endtask : waitp
  task automatic svc();
    @(negedge mclk) svc_slot = 1'b1;
    @(negedge mclk) svc_slot = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : svc
  ////////////////////////////////////////////////////////////
  initial begin
    sp(32'h0, 0);
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    sp(32'h0, 0);
    // 8-bit register access, abort in mid-byte
    sp({8'h20, 8'h03, 8'hA5}, 24);
    chk("chain0", ch[23:16], 8'h27);
    sp(32'h1F, 5);
    sp({8'h60, 8'h03, 8'h00}, 24);
    chk("rd8", rx[7:0], 8'hA5);
    $display("test reg8 done");
    // 8-bit register access in a 32-bit frame, byte repeated in the pad
    sp({8'h20, 8'h04, 8'h5A, 8'h3C}, 32);
    sp({8'h60, 8'h04, 16'h0000}, 32);
    chk("rd16", rx[15:0], 16'h5A5A);
    $display("test reg16 done");
    // second channel and broadcast
    sp({8'h28, 8'h03, 8'h77}, 24);
    chk("chain1", ch[23:16], 8'h2F);
    sp({8'hA0, 8'h05, 8'h99}, 24);
    chk("chainb", ch[23:16], 8'hA0);
    foreach (rd[i]) begin
      sp({8'h00, rd[i][23:8], 8'h00}, 24);
      chk("rdch", rx[7:0], rd[i][7:0]);
    end
    sp({8'hE0, 8'h05, 8'h00}, 24);
    chk("bcrd", rx[7:0], 8'h00);
    $display("test chain done");
    // ram writes on both channels
    sp({8'h00, 8'h12, 16'hBEEF}, 32);
    sp({8'h08, 8'h34, 16'hCAFE}, 32);
    waitp(2'h3);
    sp({8'h60, 8'h0F, 8'h00}, 24);
    chk("stat", rx[0], 1'b1);
    svc();
    waitp(2'h0);
    chk("nacc", nacc, 32'd2);
    chk("lastw", la, {1'b1, 7'h00, 8'h34, 16'hCAFE});
    $display("test ramwr done");
    // ram read pipeline
    ram_rdata = 16'h1234;
    sp({8'h40, 8'h56, 16'h0000}, 32);
    chk("ramrd1", rx[15:0], 16'hBEEF);
    waitp(2'h1);
    svc();
    waitp(2'h0);
    chk("rdreq", la[31:16], 16'h0056);
    sp({8'h40, 8'h56, 16'h0000}, 32);
    chk("ramrd2", rx[15:0], 16'h1234);
    $display("test ramrd done");
    results();
  end
endmodule : test_spi_register_ram_access
